// ### bench/pulse_measure_timer_asserts.sv
// Purpose: bus handshake checks at the timer's ports
// Assumes: one clock domain, mclk, rstn asynchronous
// Notes: attached by the bind below
`timescale 1ns/10ps
`default_nettype none
module pulse_measure_timer_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // handshake properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  byte_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
    else $error("write answer not released");
endmodule // pulse_measure_timer_asserts
bind pulse_measure_timer pulse_measure_timer_asserts i_pulse_measure_timer_asserts (
  .mclk, .rstn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ### bench/pulse_measure_timer_tb.sv
// Purpose: self-checking bench for the pulse measure timer
// Assumes: mclk 250 MHz, sub clock divisor shortened to 4
// Notes: a monitor checks read data and write answers against queues
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pulse_measure_timer_tb;
  localparam int CTL = 0, IOC = 1, MDR = 2, PRE = 3, CNT = 4;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [pulse_measure_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic timer_irq, measured_pulse_pin, prev_irq;
  logic [7:0] hi_len = 8'h1e, lo_len = 8'h32, last_rd, v;
  logic [17:0] q_rd[$];
  logic [17:0] ex;
  logic [1:0] q_wr[$], ew;
  int fail_count = 0, n_compared = 0, n_irq;
  pulse_measure_timer #(.OSC_DIV(8), .SUB_DIV(4)) i_pulse_measure_timer (
    .mclk, .rstn, .measured_pulse_pin, .timer_irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  pulse_source i_pulse_source (.mclk, .run, .hi_len, .lo_len, .pin(measured_pulse_pin));
  // ------------------------------------------------------------
  // clock, bus tasks and monitor
  // ------------------------------------------------------------
  initial forever #2 mclk = ~mclk;
  task automatic wr(input int r, input logic [7:0] d,
                    input logic [1:0] resp = pulse_measure_pkg::RESP_OKAY);
    q_wr.push_back(resp);
    s_axi_awaddr <= {pulse_measure_pkg::IDX_TIMER_CONTROL + 12'(r), 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rd(input int r, input logic [7:0] e, input logic [7:0] m,
                    input logic [1:0] resp = pulse_measure_pkg::RESP_OKAY);
    q_rd.push_back({resp, e, m});
    s_axi_araddr <= {pulse_measure_pkg::IDX_TIMER_CONTROL + 12'(r), 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        last_rd = s_axi_rdata[7:0];
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  task automatic setup(input logic [2:0] md, input logic [2:0] src, input logic [7:0] io);
    wr(MDR, {1'b0, src, 1'b0, md});
    wr(IOC, io);
    wr(CTL, 8'h00);
    wr(PRE, 8'hff);
    wr(CNT, 8'hff);
  endtask
  // takes the oldest note whenever a bus answer is handed over
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      ex = q_rd.pop_front();
      `CHK("rdata", {24'h0, ex[15:8] & ex[7:0]}, s_axi_rdata & {24'hffffff, ex[7:0]})
      `CHK("rresp", ex[17:16], s_axi_rresp)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      ew = q_wr.pop_front();
      `CHK("bresp", ew, s_axi_bresp)
    end
  end
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(23682));
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int r = 0; r < 5; r++) rd(r, (r > 2) ? 8'hff : 8'h00, 8'hff);
    wr(7, 8'h00, pulse_measure_pkg::RESP_SLVERR);
    rd(7, 8'h00, 8'hff, pulse_measure_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      v = {2'b00, 2'(f), 3'b000, 1'($urandom)};
      wr(IOC, v);
      rd(IOC, v, 8'hff);
      v = 8'($urandom);
      wr(f[0] ? PRE : CNT, v);
      rd(f[0] ? PRE : CNT, v, 8'hff);
    end
    $display("test registers done");
    for (int s = 0; s < 7; s++) begin
      setup(pulse_measure_pkg::MODE_PERIOD, 3'(s), 8'h00);
      wr(CTL, 8'h01);
      repeat (300) @(posedge mclk);
      rd(CTL, {6'h00, s < 6, 1'b1}, 8'h03);
      wr(CTL, 8'h00);
      repeat (300) @(posedge mclk);
      rd(CTL, 8'h00, 8'h03);
      rd(PRE, 8'h00, 8'h00);
      `CHK("tick", s < 6, last_rd !== 8'hff)
      rd(PRE, last_rd, 8'hff);
    end
    $display("test sources done");
    setup(pulse_measure_pkg::MODE_PERIOD, pulse_measure_pkg::SRC_DIV1, 8'h00);
    wr(PRE, 8'h03);
    wr(CNT, 8'h04);
    wr(CTL, 8'h01);
    n_irq = 0;
    prev_irq = 1'b0;
    repeat (200) begin
      @(posedge mclk);
      if (timer_irq === 1'b1) n_irq++;
      `CHK("irq pulse", 1'b0, prev_irq & timer_irq)
      prev_irq = timer_irq;
    end
    `CHK("irq count", 1'b1, n_irq inside {[9:11]})
    wr(CTL, 8'h18);
    rd(CTL, 8'h10, 8'h13);
    wr(CTL, 8'h08);
    rd(CTL, 8'h00, 8'h10);
    $display("test underflow done");
    for (int p = 0; p < 2; p++) begin
      setup(pulse_measure_pkg::MODE_PERIOD, pulse_measure_pkg::SRC_DIV1, 8'(p));
      wr(PRE, 8'h03);
      wr(CTL, 8'h01);
      hi_len <= p ? 8'h32 : 8'h1e;
      run <= 1'b1;
      repeat (400) @(posedge mclk);
      rd(CTL, 8'h08, 8'h08);
      rd(CNT, 8'h00, 8'h00);
      v = p ? 8'he8 : 8'hed; // two prescaler periods lost, one to the reload, one to the latch
      `CHK("period", 1'b1, last_rd inside {[v - 8'h01:v + 8'h01]})
      wr(CTL, 8'h00);
      run <= 1'b0;
    end
    $display("test period done");
    hi_len <= 8'h02; // passes the synchroniser, not the filter
    for (int f = 0; f < 4; f++) begin
      setup(pulse_measure_pkg::MODE_WIDTH, pulse_measure_pkg::SRC_DIV1, {2'b00, 2'(f), 4'h1});
      wr(CTL, 8'h01);
      run <= 1'b1;
      repeat (200) @(posedge mclk);
      wr(CTL, 8'h00);
      run <= 1'b0;
      repeat (5) @(posedge mclk);
      rd(PRE, 8'h00, 8'h00);
      `CHK("width glitch", f == 0, last_rd !== 8'hff)
    end
    $display("test width done");
    setup(pulse_measure_pkg::MODE_WIDTH, pulse_measure_pkg::SRC_DIV1, 8'h00);
    wr(CTL, 8'h01);
    repeat (20) @(posedge mclk);
    wr(PRE, 8'h07);
    repeat (5) @(posedge mclk);
    wr(CNT, 8'h40);
    repeat (40) @(posedge mclk);
    wr(CTL, 8'h00);
    repeat (5) @(posedge mclk);
    rd(CNT, 8'h00, 8'h00);
    `CHK("live write", 1'b1, last_rd inside {[8'h3a:8'h40]})
    wr(CTL, 8'h01);
    repeat (20) @(posedge mclk);
    wr(CTL, 8'h04);
    rd(CTL, 8'h00, 8'h07);
    $display("test live write and forced stop done");
    conclude();
  end
endmodule // pulse_measure_timer_tb
`default_nettype wire

// ### bench/pulse_source.sv
// Purpose: external source on the measured pulse pin
// Assumes: phase lengths in mclk cycles, at least one
// Notes: a scenario may ask for glitches shorter than a prescaler period
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
  input wire logic mclk,
  input wire logic run,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  output logic pin
);
  logic [7:0] left_q = 8'h00;
  initial pin = 1'b0;
  // alternates high and low phases while running, rests low otherwise
  always @(posedge mclk) begin
    if (!run) begin
      pin <= 1'b0;
      left_q <= 8'h00;
    end else if (left_q == 8'h00) begin
      pin <= !pin;
      left_q <= pin ? lo_len - 8'h01 : hi_len - 8'h01;
    end else begin
      left_q <= left_q - 8'h01;
    end
  end
endmodule // pulse_source
`default_nettype wire

// ### design/filter_if.sv
// Purpose: carries the filter control and the accepted pin level
// Assumes: one clock domain, mclk
// Notes: ctl side is the timer, flt side is the input filter
`timescale 1ns/10ps
`default_nettype none
interface filter_if;
  logic bypass;
  logic sample_en;
  logic level;
  modport ctl (output bypass, output sample_en, input level);
  modport flt (input bypass, input sample_en, output level);
endinterface
`default_nettype wire

// ### design/pin_filter.sv
// Purpose: synchronises the measured pulse pin and filters it
// Assumes: sample_en is a one-cycle pulse from the timer's divider, or held high for div1
// Notes: a filtered level is accepted after three equal samples; bypass takes the synchroniser output once its last two stages agree
`timescale 1ns/10ps
`default_nettype none
module pin_filter (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pin_i,
  filter_if.flt fif
);

  typedef struct packed {
    logic [2:0] sync;
    logic [2:0] smp;
    logic level;
  } flt_s;

  flt_s st_q;
  flt_s st_d;

  assign fif.level = st_q.level;

  // three stage synchroniser, then optional three sample filter
  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], pin_i};
    if (fif.bypass) begin
      if (st_q.sync[1] == st_q.sync[2]) begin
        st_d.level = st_q.sync[2];
      end
    end else if (fif.sample_en && (st_q.sync[1] == st_q.sync[2])) begin
      st_d.smp = {st_q.smp[1:0], st_q.sync[2]};
      if ((st_q.smp[1:0] == {2{st_q.sync[2]}})) begin
        st_d.level = st_q.sync[2];
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // pin_filter
`default_nettype wire

// ### design/pulse_measure_pkg.sv
// Purpose: constants shared by the pulse measurement timer and its input filter
// Assumes: registers are 8 bits wide and sit at word index times four
// Notes: indices are kept as printed or chosen; byte address is index * 4
package pulse_measure_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam logic [11:0] IDX_TIMER_CONTROL = 12'h100;
  localparam logic [11:0] IDX_PIN_IO_CONTROL = 12'h101;
  localparam logic [11:0] IDX_TIMER_MODE = 12'h102;
  localparam logic [11:0] IDX_PRESCALER = 12'h103;
  localparam logic [11:0] IDX_MAIN_COUNTER = 12'h104;
  localparam int ADDR_W = 14;

  // ----------------------------------------------------------------------
  // timer_control_reg fields
  // ----------------------------------------------------------------------
  localparam int CTL_START = 0;
  localparam int CTL_STATUS = 1;
  localparam int CTL_FSTOP = 2;
  localparam int CTL_EDGE_F = 3;
  localparam int CTL_UNF_F = 4;

  // ----------------------------------------------------------------------
  // timer_pin_io_control fields
  // ----------------------------------------------------------------------
  localparam int IO_EDGE_POL = 0;
  localparam int IO_FILT_LO = 4;
  localparam int IO_FILT_HI = 5;
  localparam logic [7:0] IO_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // timer_mode_reg fields and codes
  // ----------------------------------------------------------------------
  localparam int MODE_LO = 0;
  localparam int MODE_HI = 2;
  localparam int SRC_LO = 4;
  localparam int SRC_HI = 6;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'hff;

  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_WIDTH = 3'b011,
    MODE_PERIOD = 3'b100
  } meas_mode_e;

  typedef enum logic [2:0] {
    SRC_DIV1 = 3'b000,
    SRC_DIV8 = 3'b001,
    SRC_OSC = 3'b010,
    SRC_DIV2 = 3'b011,
    SRC_SUB32 = 3'b100,
    SRC_SUB = 3'b101
  } count_src_e;

  typedef enum logic [1:0] {
    FILT_NONE = 2'b00,
    FILT_DIV1 = 2'b01,
    FILT_DIV8 = 2'b10,
    FILT_DIV32 = 2'b11
  } filter_sel_e;

  // ----------------------------------------------------------------------
  // bus answers and divider figures
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [4:0] SUB32_LAST = 5'h1f;
  localparam int OSC_DIV_DEF = 8;
  localparam int SUB_DIV_DEF = 7629;

endpackage

// ### design/pulse_measure_timer.sv
// Purpose: pulse width and pulse period measurement timer, 8-bit counter
//          with 8-bit prescaler, registers over AXI4-Lite
// Assumes: mclk at 250 MHz; on-chip oscillator and sub clock rates are
//          derived from mclk by parameter divisors
// Notes: registers are 8 bits in the low byte lane of a 32-bit word
`timescale 1ns/10ps
`default_nettype none
// Function
// - count source is one of six selectable clocks, decrementing
// - period mode: latch read-out at first prescaler underflow, reload at second
// - writing start bit 1 begins counting
// - writing start bit 0 stops; writing forced stop 1 stops at once
// - period mode: interrupt on underflow, reload and period end edge
// - prescaler is readable in both measurement modes; counter reads the latched value in period mode
// - writes while stopped load reload register and counter
// - writes while counting load reload register; prescaler at next tick, counter at next prescaler underflow
// - edge polarity bit picks rising-to-rising or falling-to-falling period
// - filter field picks none, div1, div8 or div32 sampling
// - filtered level accepted after three equal samples
// - period flags clear on written 0, keep on written 1
// - edge flag may set at first prescaler underflow after start
// - status follows start within one count-source cycle
// - status drops within one count-source cycle after start clears
// - stopped after reset; bytes read independently
// - width mode counts only while input is at selected level
module pulse_measure_timer #(
  parameter int OSC_DIV = pulse_measure_pkg::OSC_DIV_DEF,
  parameter int SUB_DIV = pulse_measure_pkg::SUB_DIV_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic measured_pulse_pin,
  output logic timer_irq,
  input wire logic [pulse_measure_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pulse_measure_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awv;
    logic [11:0] awidx;
    logic wv;
    logic [7:0] wd;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic start;
    logic status;
    logic edge_f;
    logic unf_f;
    logic [7:0] pin_io;
    logic [7:0] mode;
    logic [7:0] pre_rel;
    logic [7:0] pre_cnt;
    logic [7:0] tmr_rel;
    logic [7:0] tmr_cnt;
    logic [7:0] rdbuf;
    logic pre_pend;
    logic tmr_pend;
    logic edge_pend;
    logic rel_pend;
    logic end_pend;
    logic lvl;
    logic irq;
    logic [4:0] div_cnt;
    logic [15:0] osc_cnt;
    logic [15:0] sub_cnt;
    logic [4:0] sub32;
  } tmr_s;

  tmr_s st_q;
  tmr_s st_d;

  filter_if fif ();

  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);
  localparam logic [15:0] SUB_LAST = 16'(SUB_DIV - 1);

  // ----------------------------------------------------------------------
  // register index decode, used by both read and write paths
  // ----------------------------------------------------------------------
  function automatic logic idx_known(input logic [11:0] idx);
    idx_known = (idx == pulse_measure_pkg::IDX_TIMER_CONTROL) ||
                (idx == pulse_measure_pkg::IDX_PIN_IO_CONTROL) ||
                (idx == pulse_measure_pkg::IDX_TIMER_MODE) ||
                (idx == pulse_measure_pkg::IDX_PRESCALER) ||
                (idx == pulse_measure_pkg::IDX_MAIN_COUNTER);
  endfunction

  // ----------------------------------------------------------------------
  // rate enables and filter hookup
  // ----------------------------------------------------------------------
  logic en_div2;
  logic en_div8;
  logic en_div32;
  logic en_osc;
  logic en_sub;
  logic en_sub32;
  logic tick;
  logic measuring;
  logic period_mode;
  logic width_mode;
  logic rise;
  logic fall;
  logic act_edge;
  logic [7:0] ctl_rd;
  logic [1:0] filt;

  assign en_div2 = st_q.div_cnt[0];
  assign en_div8 = (st_q.div_cnt[2:0] == pulse_measure_pkg::DIV8_LAST[2:0]);
  assign en_div32 = (st_q.div_cnt == pulse_measure_pkg::DIV32_LAST);
  assign en_osc = (st_q.osc_cnt == OSC_LAST);
  assign en_sub = (st_q.sub_cnt == SUB_LAST);
  assign en_sub32 = en_sub && (st_q.sub32 == pulse_measure_pkg::SUB32_LAST);
  assign filt = st_q.pin_io[pulse_measure_pkg::IO_FILT_HI:pulse_measure_pkg::IO_FILT_LO];
  assign period_mode = (st_q.mode[pulse_measure_pkg::MODE_HI:pulse_measure_pkg::MODE_LO]
                        == pulse_measure_pkg::MODE_PERIOD);
  assign width_mode = (st_q.mode[pulse_measure_pkg::MODE_HI:pulse_measure_pkg::MODE_LO]
                       == pulse_measure_pkg::MODE_WIDTH);
  assign measuring = period_mode || width_mode;
  assign rise = fif.level && !st_q.lvl;
  assign fall = !fif.level && st_q.lvl;
  // period edge choice: 0 rising to rising, 1 falling to falling
  assign act_edge = st_q.pin_io[pulse_measure_pkg::IO_EDGE_POL] ? fall : rise;

  // filter sampling rate
  always_comb begin
    fif.bypass = (filt == pulse_measure_pkg::FILT_NONE);
    case (filt)
      pulse_measure_pkg::FILT_DIV1: fif.sample_en = 1'b1;
      pulse_measure_pkg::FILT_DIV8: fif.sample_en = en_div8;
      pulse_measure_pkg::FILT_DIV32: fif.sample_en = en_div32;
      default: fif.sample_en = 1'b0;
    endcase
  end

  // count source select
  always_comb begin
    case (st_q.mode[pulse_measure_pkg::SRC_HI:pulse_measure_pkg::SRC_LO])
      pulse_measure_pkg::SRC_DIV1: tick = 1'b1;
      pulse_measure_pkg::SRC_DIV2: tick = en_div2;
      pulse_measure_pkg::SRC_DIV8: tick = en_div8;
      pulse_measure_pkg::SRC_OSC: tick = en_osc;
      pulse_measure_pkg::SRC_SUB32: tick = en_sub32;
      pulse_measure_pkg::SRC_SUB: tick = en_sub;
      default: tick = 1'b0;
    endcase
  end

  pin_filter u_filter (
    .mclk(mclk),
    .rstn(rstn),
    .pin_i(measured_pulse_pin),
    .fif(fif)
  );

  // control register read image; forced stop always reads 0
  assign ctl_rd = {3'h0, st_q.unf_f, st_q.edge_f, 1'b0, st_q.status, st_q.start};

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic do_wr;
    logic pre_unf;
    logic tmr_unf;
    logic count_en;
    logic ev;
    do_wr = 1'b0;
    pre_unf = 1'b0;
    tmr_unf = 1'b0;
    count_en = 1'b0;
    ev = 1'b0;
    st_d = st_q;

    // free running dividers
    st_d.div_cnt = st_q.div_cnt + 5'h01;
    st_d.osc_cnt = en_osc ? 16'h0000 : st_q.osc_cnt + 16'h0001;
    st_d.sub_cnt = en_sub ? 16'h0000 : st_q.sub_cnt + 16'h0001;
    if (en_sub) begin
      st_d.sub32 = st_q.sub32 + 5'h01;
    end

    // write channel: take address and data in either order
    if (s_axi_awvalid && !st_q.awv && !st_q.bvalid) begin
      st_d.awv = 1'b1;
      st_d.awidx = s_axi_awaddr[pulse_measure_pkg::ADDR_W-1:2];
    end
    if (s_axi_wvalid && !st_q.wv && !st_q.bvalid) begin
      st_d.wv = 1'b1;
      st_d.wd = s_axi_wdata[7:0];
      st_d.wlane = s_axi_wstrb[0];
    end
    if (st_q.awv && st_q.wv) begin
      do_wr = st_q.wlane && idx_known(st_q.awidx);
      st_d.awv = 1'b0;
      st_d.wv = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = idx_known(st_q.awidx) ? pulse_measure_pkg::RESP_OKAY
                                         : pulse_measure_pkg::RESP_SLVERR;
    end else if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // read channel: one read at a time, answer one cycle after the take
    if (st_q.arready && s_axi_arvalid) begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rresp = idx_known(s_axi_araddr[pulse_measure_pkg::ADDR_W-1:2])
                   ? pulse_measure_pkg::RESP_OKAY : pulse_measure_pkg::RESP_SLVERR;
      case (s_axi_araddr[pulse_measure_pkg::ADDR_W-1:2])
        pulse_measure_pkg::IDX_TIMER_CONTROL: st_d.rdata = ctl_rd;
        pulse_measure_pkg::IDX_PIN_IO_CONTROL: st_d.rdata = st_q.pin_io;
        pulse_measure_pkg::IDX_TIMER_MODE: st_d.rdata = st_q.mode;
        pulse_measure_pkg::IDX_PRESCALER: st_d.rdata = st_q.pre_cnt;
        pulse_measure_pkg::IDX_MAIN_COUNTER:
          st_d.rdata = period_mode ? st_q.rdbuf : st_q.tmr_cnt;
        default: st_d.rdata = 8'h00;
      endcase
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end

    // software writes to the registers
    if (do_wr) begin
      case (st_q.awidx)
        pulse_measure_pkg::IDX_TIMER_CONTROL: begin
          st_d.start = st_q.wd[pulse_measure_pkg::CTL_START];
          if (period_mode) begin
            st_d.edge_f = st_q.edge_f & st_q.wd[pulse_measure_pkg::CTL_EDGE_F];
            st_d.unf_f = st_q.unf_f & st_q.wd[pulse_measure_pkg::CTL_UNF_F];
          end
          if (st_q.wd[pulse_measure_pkg::CTL_FSTOP]) begin
            st_d.start = 1'b0;
            st_d.status = 1'b0;
            st_d.pre_pend = 1'b0;
            st_d.tmr_pend = 1'b0;
            st_d.edge_pend = 1'b0;
            st_d.rel_pend = 1'b0;
            st_d.end_pend = 1'b0;
          end
        end
        pulse_measure_pkg::IDX_PIN_IO_CONTROL: st_d.pin_io = st_q.wd;
        pulse_measure_pkg::IDX_TIMER_MODE: st_d.mode = st_q.wd;
        pulse_measure_pkg::IDX_PRESCALER: begin
          st_d.pre_rel = st_q.wd;
          if (st_q.status) begin
            st_d.pre_pend = 1'b1;
          end else begin
            st_d.pre_cnt = st_q.wd;
          end
        end
        pulse_measure_pkg::IDX_MAIN_COUNTER: begin
          st_d.tmr_rel = st_q.wd;
          if (st_q.status) begin
            st_d.tmr_pend = 1'b1;
          end else begin
            st_d.tmr_cnt = st_q.wd;
          end
        end
        default: st_d.tmr_rel = st_q.tmr_rel;
      endcase
    end

    // input edges are caught every mclk; width mode acts at the next tick, period mode at the next prescaler underflow
    st_d.lvl = fif.level;
    if (st_q.status && period_mode && act_edge) begin
      st_d.edge_pend = 1'b1;
    end
    if (st_q.status && width_mode &&
        (st_q.pin_io[pulse_measure_pkg::IO_EDGE_POL] ? fall : rise)) begin
      st_d.end_pend = 1'b1;
    end

    // count-source cycle: status follows start, then counting
    if (tick) begin
      st_d.irq = 1'b0;
      if (!(do_wr && st_q.awidx == pulse_measure_pkg::IDX_TIMER_CONTROL &&
            st_q.wd[pulse_measure_pkg::CTL_FSTOP])) begin
        st_d.status = st_q.start;
      end
      // width mode counts only at the measured level; 1 = high level
      count_en = st_q.status && measuring &&
                 (!width_mode ||
                  (fif.level == st_q.pin_io[pulse_measure_pkg::IO_EDGE_POL]));
      if (st_q.status && st_q.pre_pend) begin
        st_d.pre_cnt = st_q.pre_rel;
        st_d.pre_pend = 1'b0;
      end else if (count_en) begin
        pre_unf = (st_q.pre_cnt == 8'h00);
        st_d.pre_cnt = pre_unf ? st_q.pre_rel : st_q.pre_cnt - 8'h01;
      end
      if (pre_unf) begin
        if (st_q.tmr_pend) begin
          st_d.tmr_cnt = st_q.tmr_rel;
          st_d.tmr_pend = 1'b0;
        end else if (period_mode && st_q.rel_pend) begin
          st_d.tmr_cnt = st_q.tmr_rel;
          st_d.rel_pend = 1'b0;
          ev = 1'b1;
        end else begin
          tmr_unf = (st_q.tmr_cnt == 8'h00);
          st_d.tmr_cnt = tmr_unf ? st_q.tmr_rel : st_q.tmr_cnt - 8'h01;
        end
        if (period_mode && st_q.edge_pend) begin
          st_d.rdbuf = st_q.tmr_cnt;
          st_d.edge_pend = 1'b0;
          st_d.rel_pend = 1'b1;
          st_d.edge_f = 1'b1;
          ev = 1'b1;
        end
      end
      if (tmr_unf) begin
        ev = 1'b1;
        if (period_mode) begin
          st_d.unf_f = 1'b1;
        end
      end
      if (width_mode && st_q.end_pend && st_q.status) begin
        st_d.end_pend = 1'b0;
        ev = 1'b1;
      end
      st_d.irq = ev;
    end
  end

  // ----------------------------------------------------------------------
  // state register, stopped after reset
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.arready <= 1'b1;
      st_q.pin_io <= pulse_measure_pkg::IO_RESET;
      st_q.mode <= pulse_measure_pkg::MODE_RESET;
      st_q.pre_rel <= pulse_measure_pkg::CNT_RESET;
      st_q.pre_cnt <= pulse_measure_pkg::CNT_RESET;
      st_q.tmr_rel <= pulse_measure_pkg::CNT_RESET;
      st_q.tmr_cnt <= pulse_measure_pkg::CNT_RESET;
      st_q.rdbuf <= pulse_measure_pkg::CNT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign timer_irq = st_q.irq;
  assign s_axi_awready = !st_q.awv && !st_q.bvalid;
  assign s_axi_wready = !st_q.wv && !st_q.bvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = {24'h000000, st_q.rdata};
  assign s_axi_rresp = st_q.rresp;

endmodule // pulse_measure_timer
`default_nettype wire
